// ==== hw/tlic_ctrl.sv ====
// Three-level interrupt controller top: registers, arbitration, nesting.
module tlic_ctrl #(
  parameter int unsigned WAKE_N = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Register byte access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Register bit access
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_wdata,
  output logic o_bit_rdata,
  // Interrupt requests, index equal to polling order
  input wire logic [tlic_pkg::NUM_SRC-1:0] i_irq_req,
  // Core handshake
  output logic o_irq_valid,
  output logic [tlic_pkg::SRC_W-1:0] o_irq_src,
  output logic [tlic_pkg::LVL_W-1:0] o_irq_level,
  input wire logic i_irq_ack,
  input wire logic i_reti,
  output logic [tlic_pkg::NUM_LEVELS-1:0] o_in_service,
  // Power management
  input wire logic i_core_shutdown_mode,
  input wire logic [WAKE_N-1:0] i_wake_event,
  input wire logic [WAKE_N-1:0] i_wake_cfg,
  output logic o_core_wake,
  // Watchdog configuration for the timer block
  output logic [7:0] o_watchdog_config
);

  localparam int unsigned N = tlic_pkg::NUM_SRC;
  localparam int unsigned L = tlic_pkg::NUM_LEVELS;
  // In-service patterns that the nesting checks compare against.
  localparam logic [L-1:0] ISR_LOW = L'(1) << tlic_pkg::LVL_LOW;
  localparam logic [L-1:0] ISR_LOW_HIGH =
    ISR_LOW | (L'(1) << tlic_pkg::LVL_HIGH);

  // ==========================================================================
  // Helpers
  // A level is blocked when it or any level above it is in service.
  function automatic logic lvl_blocked(logic [L-1:0] isr,
                                       logic [tlic_pkg::LVL_W-1:0] lvl);
    return (isr >> lvl) != '0;
  endfunction : lvl_blocked

  // Clears the highest in-service level, the one a return ends.
  function automatic logic [L-1:0] drop_top(logic [L-1:0] isr);
    logic [L-1:0] r;
    logic done;
    r = isr;
    done = 1'b0;
    for (int i = L - 1; i >= 0; i--)
    begin
      if (r[i] && !done)
      begin
        r[i] = 1'b0;
        done = 1'b1;
      end
    end
    return r;
  endfunction : drop_top

  // Mask of sources polled ahead of a given source.
  function automatic logic [N-1:0] ahead_of(logic [tlic_pkg::SRC_W-1:0] s);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++)
    begin
      m[i] = (i < int'(s));
    end
    return m;
  endfunction : ahead_of

  // ==========================================================================
  // Register set
  tlic_pkg::tlic_regs_t regs;

  tlic_sfr_bank u_bank (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata),
    .i_bit_addr(i_bit_addr),
    .i_bit_wr(i_bit_wr),
    .i_bit_wdata(i_bit_wdata),
    .o_bit_rdata(o_bit_rdata),
    .o_regs(regs)
  );

  assign o_watchdog_config = regs.watchdog_config;

  // ==========================================================================
  // Per-source enables and levels
  logic [N-1:0] src_en;
  logic [N-1:0] src_high;
  wire logic global_irq_en = regs.ie[tlic_pkg::IE_GLOBAL];

  // Enable bits; the watchdog source has no enable bit here.
  assign src_en[tlic_pkg::SRC_SUPPLY] =
    regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_SUPPLY_EN];
  assign src_en[tlic_pkg::SRC_RTC] = regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_RTC_EN];
  assign src_en[tlic_pkg::SRC_METER] = regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_METER_EN];
  assign src_en[tlic_pkg::SRC_WATCHDOG] = 1'b1;
  assign src_en[tlic_pkg::SRC_TEMP] = regs.ie[tlic_pkg::IE_TEMP];
  assign src_en[tlic_pkg::SRC_EXT0] = regs.ie[tlic_pkg::IE_EXT0];
  assign src_en[tlic_pkg::SRC_TIMER0] = regs.ie[tlic_pkg::IE_TIMER0];
  assign src_en[tlic_pkg::SRC_EXT1] = regs.ie[tlic_pkg::IE_EXT1];
  assign src_en[tlic_pkg::SRC_TIMER1] = regs.ie[tlic_pkg::IE_TIMER1];
  assign src_en[tlic_pkg::SRC_SERIAL] = regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_SERIAL_EN];
  assign src_en[tlic_pkg::SRC_UART] = regs.ie[tlic_pkg::IE_UART];
  assign src_en[tlic_pkg::SRC_TIMER2] = regs.ie[tlic_pkg::IE_TIMER2];

  // Level bits, one meaning high; supply and watchdog have none.
  assign src_high[tlic_pkg::SRC_SUPPLY] = 1'b0;
  assign src_high[tlic_pkg::SRC_RTC] = regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_RTC_HI];
  assign src_high[tlic_pkg::SRC_METER] = regs.ip[tlic_pkg::IP_METER];
  assign src_high[tlic_pkg::SRC_WATCHDOG] = 1'b0;
  assign src_high[tlic_pkg::SRC_TEMP] = regs.ip[tlic_pkg::IP_TEMP];
  assign src_high[tlic_pkg::SRC_EXT0] = regs.ip[tlic_pkg::IP_EXT0];
  assign src_high[tlic_pkg::SRC_TIMER0] = regs.ip[tlic_pkg::IP_TIMER0];
  assign src_high[tlic_pkg::SRC_EXT1] = regs.ip[tlic_pkg::IP_EXT1];
  assign src_high[tlic_pkg::SRC_TIMER1] = regs.ip[tlic_pkg::IP_TIMER1];
  assign src_high[tlic_pkg::SRC_SERIAL] =
    regs.secondary_enable_priority[tlic_pkg::SECONDARY_ENABLE_PRIORITY_SERIAL_HI];
  assign src_high[tlic_pkg::SRC_UART] = regs.ip[tlic_pkg::IP_UART];
  assign src_high[tlic_pkg::SRC_TIMER2] = regs.ip[tlic_pkg::IP_TIMER2];

  // ==========================================================================
  // Level sorting
  // Nothing is serviced while the core is shut down or globally masked.
  logic [N-1:0] pending;
  logic [N-1:0] top_mask;
  logic [L-1:0][N-1:0] lvl_req;
  logic [L-1:0] lvl_any;
  logic [L-1:0][tlic_pkg::SRC_W-1:0] lvl_idx;

  assign pending = i_irq_req & src_en &
                   {N{global_irq_en && !i_core_shutdown_mode}};
  assign top_mask = N'(1) << tlic_pkg::SRC_SUPPLY;
  assign lvl_req[tlic_pkg::LVL_TOP] = pending & top_mask;
  assign lvl_req[tlic_pkg::LVL_HIGH] = pending & ~top_mask & src_high;
  assign lvl_req[tlic_pkg::LVL_LOW] = pending & ~top_mask & ~src_high;

  // One fixed-order picker per level; index order is polling order.
  for (genvar g = 0; g < L; g++)
  begin : g_level
    tlic_pick #(
      .W(N),
      .IW(tlic_pkg::SRC_W)
    ) u_pick (
      .i_req(lvl_req[g]),
      .o_any(lvl_any[g]),
      .o_idx(lvl_idx[g])
    );
  end

  // ==========================================================================
  // Nesting record
  logic [L-1:0] isr_reg, isr_next;
  tlic_pkg::tlic_grant_t grant_reg, grant_next;
  wire logic take = grant_reg.valid && i_irq_ack;

  // A return closes the current routine before a new one is recorded.
  assign isr_next = (i_reti ? drop_top(isr_reg) : isr_reg) |
                    (take ? (L'(1) << grant_reg.level) : '0);

  // Highest unblocked level wins; arbitration sees the updated record,
  // so a taken request is never offered twice.
  always_comb
  begin
    grant_next = '0;
    for (int i = 0; i < L; i++)
    begin
      if (lvl_any[i] && !lvl_blocked(isr_next, tlic_pkg::LVL_W'(i)))
      begin
        grant_next.valid = 1'b1;
        grant_next.level = tlic_pkg::LVL_W'(i);
        grant_next.src = lvl_idx[i];
      end
    end
  end

  // ==========================================================================
  // State and outputs
  logic wake_reg, wake_next;

  assign wake_next = i_core_shutdown_mode &&
                     ((i_wake_event & i_wake_cfg) != '0);

  // Record, offered request and wake line.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      isr_reg <= '0;
      grant_reg <= '0;
      wake_reg <= 1'b0;
    end
    else
    begin
      isr_reg <= isr_next;
      grant_reg <= grant_next;
      wake_reg <= wake_next;
    end
  end

  assign o_irq_valid = grant_reg.valid;
  assign o_irq_src = grant_reg.src;
  assign o_irq_level = grant_reg.level;
  assign o_in_service = isr_reg;
  assign o_core_wake = wake_reg;

  // ==========================================================================
  // Checks
  a_src_range: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    grant_reg.valid |-> grant_reg.src < tlic_pkg::SRC_W'(N))
    else $error("offered source out of range");

  a_top_supply: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    grant_reg.valid && grant_reg.level == tlic_pkg::LVL_TOP
    |-> grant_reg.src == tlic_pkg::SRC_W'(tlic_pkg::SRC_SUPPLY))
    else $error("top level offered for a non supply source");

  a_level_map: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    grant_next.valid &&
    grant_next.src != tlic_pkg::SRC_W'(tlic_pkg::SRC_SUPPLY)
    |-> grant_next.level ==
        (src_high[grant_next.src] ? tlic_pkg::LVL_HIGH
                                  : tlic_pkg::LVL_LOW))
    else $error("source offered at wrong level");

  a_preempt_low: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    isr_reg == ISR_LOW && lvl_any[tlic_pkg::LVL_HIGH] &&
    !i_reti && !i_irq_ack
    |=> grant_reg.valid && grant_reg.level != tlic_pkg::LVL_LOW)
    else $error("high request failed to preempt low routine");

  a_higher_first: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    lvl_any[tlic_pkg::LVL_HIGH] && isr_next == '0
    |-> grant_next.valid && grant_next.level != tlic_pkg::LVL_LOW)
    else $error("low request chosen over high request");

  a_no_same_level: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    grant_reg.valid |-> !lvl_blocked(isr_reg, grant_reg.level))
    else $error("request offered at an in-service level");

  a_poll_order: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    grant_next.valid
    |-> (lvl_req[grant_next.level] & ahead_of(grant_next.src)) == '0)
    else $error("polling order violated within a level");

  a_global_off: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !global_irq_en |=> !grant_reg.valid)
    else $error("request offered with global enable clear");

  a_enable_gate: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    grant_next.valid |-> src_en[grant_next.src])
    else $error("disabled source offered");

  a_bit_write: assert property (
    @(posedge i_core_clk) disable iff (i_sys_rst)
    i_bit_wr && !i_sfr_wr && i_bit_addr[7:3] == tlic_pkg::ADDR_IE[7:3]
    |=> regs.ie[$past(i_bit_addr[2:0])] == $past(i_bit_wdata))
    else $error("enable bit write lost");

  a_fixed_ones: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    i_sfr_addr == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY
    |=> (o_sfr_rdata & tlic_pkg::SECONDARY_ENABLE_PRIORITY_FIXED_ONES) ==
        tlic_pkg::SECONDARY_ENABLE_PRIORITY_FIXED_ONES)
    else $error("secondary register unused bits not one");

  a_shutdown_quiet: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    i_core_shutdown_mode [*2] |-> !grant_reg.valid)
    else $error("interrupt offered while core shut down");

  a_reti_release: assert property (
    @(posedge i_core_clk)
    disable iff (i_sys_rst)
    i_reti && !i_irq_ack && isr_reg == ISR_LOW_HIGH
    |=> isr_reg == ISR_LOW)
    else $error("return did not release top in-service level");

endmodule : tlic_ctrl

// ==== hw/tlic_pkg.sv ====
// Constants, register layout and carrier types of the interrupt controller.
package tlic_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_SRC = 12;
  localparam int unsigned NUM_LEVELS = 3;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned LVL_W = 2;

  // ==========================================================================
  // Byte addresses and reset values
  localparam logic [7:0] ADDR_IE = 8'ha8;
  localparam logic [7:0] ADDR_SECONDARY_ENABLE_PRIORITY = 8'ha9;
  localparam logic [7:0] ADDR_IP = 8'hb8;
  localparam logic [7:0] ADDR_WATCHDOG_CONFIG = 8'hc0;
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_IP = 8'h00;
  localparam logic [7:0] RST_SECONDARY_ENABLE_PRIORITY = 8'ha0;
  localparam logic [7:0] RST_WATCHDOG_CONFIG = 8'h10;
  // Unused secondary bits read back as their reset value of one.
  localparam logic [7:0] SECONDARY_ENABLE_PRIORITY_FIXED_ONES = 8'ha0;
  localparam logic [7:0] SECONDARY_ENABLE_PRIORITY_WR_MASK = 8'h5f;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ==========================================================================
  // Field positions of the enable register
  localparam int unsigned IE_GLOBAL = 7;
  localparam int unsigned IE_TEMP = 6;
  localparam int unsigned IE_TIMER2 = 5;
  localparam int unsigned IE_UART = 4;
  localparam int unsigned IE_TIMER1 = 3;
  localparam int unsigned IE_EXT1 = 2;
  localparam int unsigned IE_TIMER0 = 1;
  localparam int unsigned IE_EXT0 = 0;
  // Field positions of the level select register.
  localparam int unsigned IP_METER = 7;
  localparam int unsigned IP_TEMP = 6;
  localparam int unsigned IP_TIMER2 = 5;
  localparam int unsigned IP_UART = 4;
  localparam int unsigned IP_TIMER1 = 3;
  localparam int unsigned IP_EXT1 = 2;
  localparam int unsigned IP_TIMER0 = 1;
  localparam int unsigned IP_EXT0 = 0;
  // Field positions of the secondary register.
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_RTC_HI = 6;
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_SERIAL_HI = 4;
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_METER_EN = 3;
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_RTC_EN = 2;
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_SUPPLY_EN = 1;
  localparam int unsigned SECONDARY_ENABLE_PRIORITY_SERIAL_EN = 0;

  // ==========================================================================
  // Source numbers, equal to the polling order (0 is polled first)
  localparam int unsigned SRC_SUPPLY = 0;
  localparam int unsigned SRC_RTC = 1;
  localparam int unsigned SRC_METER = 2;
  localparam int unsigned SRC_WATCHDOG = 3;
  localparam int unsigned SRC_TEMP = 4;
  localparam int unsigned SRC_EXT0 = 5;
  localparam int unsigned SRC_TIMER0 = 6;
  localparam int unsigned SRC_EXT1 = 7;
  localparam int unsigned SRC_TIMER1 = 8;
  localparam int unsigned SRC_SERIAL = 9;
  localparam int unsigned SRC_UART = 10;
  localparam int unsigned SRC_TIMER2 = 11;

  // ==========================================================================
  // Levels
  localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
  localparam logic [LVL_W-1:0] LVL_HIGH = 2'h1;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] secondary_enable_priority;
    logic [7:0] watchdog_config;
  } tlic_regs_t;

  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
    logic [SRC_W-1:0] src;
  } tlic_grant_t;

endpackage : tlic_pkg

// ==== hw/tlic_pick.sv ====
// Fixed-order picker: finds the lowest-numbered set request.
module tlic_pick #(
  parameter int unsigned W = 12,
  parameter int unsigned IW = 4
) (
  // Requests, bit 0 polled first
  input wire logic [W-1:0] i_req,
  // Result
  output logic o_any,
  output logic [IW-1:0] o_idx
);

  // ==========================================================================
  // Selection
  // Scanning downward lets the lowest index overwrite any earlier find.
  always_comb
  begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (i_req[i])
      begin
        o_any = 1'b1;
        o_idx = IW'(i);
      end
    end
  end

endmodule : tlic_pick

// ==== hw/tlic_sfr_bank.sv ====
// Interrupt register set with byte and single-bit access from the core.
module tlic_sfr_bank (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Byte access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Bit access
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_wdata,
  output logic o_bit_rdata,
  // Register contents
  output tlic_pkg::tlic_regs_t o_regs
);

  // ==========================================================================
  // Helpers
  // A bit address hits a register when its upper five bits match.
  function automatic logic bit_hit(logic [7:0] baddr, logic [7:0] base);
    return baddr[7:3] == base[7:3];
  endfunction : bit_hit

  function automatic logic [7:0] put_bit(logic [7:0] v, logic [2:0] pos,
                                         logic b);
    logic [7:0] r;
    r = v;
    r[pos] = b;
    return r;
  endfunction : put_bit

  // ==========================================================================
  // Decode
  logic [7:0] ie_reg, ip_reg, secondary_enable_priority_reg, watchdog_config_reg;
  logic [7:0] ie_next, ip_next, secondary_enable_priority_next, watchdog_config_next;
  logic [7:0] rdata_reg, rdata_next;
  logic bit_rdata_reg, bit_rdata_next;
  logic [7:0] secondary_enable_priority_view;

  wire logic wr_ie = i_sfr_wr && i_sfr_addr == tlic_pkg::ADDR_IE;
  wire logic wr_ip = i_sfr_wr && i_sfr_addr == tlic_pkg::ADDR_IP;
  wire logic wr_secondary_enable_priority = i_sfr_wr && i_sfr_addr == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY;
  wire logic wr_watchdog_config = i_sfr_wr && i_sfr_addr == tlic_pkg::ADDR_WATCHDOG_CONFIG;
  wire logic bhit_ie = bit_hit(i_bit_addr, tlic_pkg::ADDR_IE);
  wire logic bhit_ip = bit_hit(i_bit_addr, tlic_pkg::ADDR_IP);
  wire logic bhit_wd = bit_hit(i_bit_addr, tlic_pkg::ADDR_WATCHDOG_CONFIG);
  wire logic [2:0] bpos = i_bit_addr[2:0];

  // Byte writes win over a bit write to the same register in one cycle.
  assign ie_next = wr_ie ? i_sfr_wdata :
                   (i_bit_wr && bhit_ie) ?
                   put_bit(ie_reg, bpos, i_bit_wdata) : ie_reg;
  assign ip_next = wr_ip ? i_sfr_wdata :
                   (i_bit_wr && bhit_ip) ?
                   put_bit(ip_reg, bpos, i_bit_wdata) : ip_reg;
  assign watchdog_config_next = wr_watchdog_config ? i_sfr_wdata :
                      (i_bit_wr && bhit_wd) ?
                      put_bit(watchdog_config_reg, bpos, i_bit_wdata) : watchdog_config_reg;
  // The secondary register has no bit addresses; only bytes reach it.
  assign secondary_enable_priority_next = wr_secondary_enable_priority ? (i_sfr_wdata & tlic_pkg::SECONDARY_ENABLE_PRIORITY_WR_MASK)
                               : secondary_enable_priority_reg;
  assign secondary_enable_priority_view = secondary_enable_priority_reg | tlic_pkg::SECONDARY_ENABLE_PRIORITY_FIXED_ONES;

  // Read multiplexers; unmapped addresses read as zero.
  assign rdata_next = (i_sfr_addr == tlic_pkg::ADDR_IE) ? ie_reg :
                      (i_sfr_addr == tlic_pkg::ADDR_IP) ? ip_reg :
                      (i_sfr_addr == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY) ? secondary_enable_priority_view :
                      (i_sfr_addr == tlic_pkg::ADDR_WATCHDOG_CONFIG) ? watchdog_config_reg :
                      tlic_pkg::RDATA_NONE;
  assign bit_rdata_next = bhit_ie ? ie_reg[bpos] :
                          bhit_ip ? ip_reg[bpos] :
                          bhit_wd ? watchdog_config_reg[bpos] : 1'b0;

  // ==========================================================================
  // Storage
  // Registers and read data; reads take one cycle.
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ie_reg <= tlic_pkg::RST_IE;
      ip_reg <= tlic_pkg::RST_IP;
      secondary_enable_priority_reg <= tlic_pkg::RST_SECONDARY_ENABLE_PRIORITY & tlic_pkg::SECONDARY_ENABLE_PRIORITY_WR_MASK;
      watchdog_config_reg <= tlic_pkg::RST_WATCHDOG_CONFIG;
      rdata_reg <= tlic_pkg::RDATA_NONE;
      bit_rdata_reg <= 1'b0;
    end
    else
    begin
      ie_reg <= ie_next;
      ip_reg <= ip_next;
      secondary_enable_priority_reg <= secondary_enable_priority_next;
      watchdog_config_reg <= watchdog_config_next;
      rdata_reg <= rdata_next;
      bit_rdata_reg <= bit_rdata_next;
    end
  end

  assign o_sfr_rdata = rdata_reg;
  assign o_bit_rdata = bit_rdata_reg;
  assign o_regs.ie = ie_reg;
  assign o_regs.ip = ip_reg;
  assign o_regs.secondary_enable_priority = secondary_enable_priority_view;
  assign o_regs.watchdog_config = watchdog_config_reg;

endmodule : tlic_sfr_bank

// ==== tb/tlic_core_model.sv ====
// Behavioural processor core that takes interrupt offers from the controller.
module tlic_core_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Offer from the controller, and the acknowledge enable from the testbench
  input wire logic i_irq_valid,
  input wire logic [tlic_pkg::SRC_W-1:0] i_irq_src,
  input wire logic i_ack_en,
  // Answer to the controller, and the taken source for the testbench
  output logic o_irq_ack,
  output logic [tlic_pkg::SRC_W-1:0] o_taken_src
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Acknowledge
  // The ack rises just after an edge and lasts one cycle, so it is sampled
  // with the very offer it answers; a slow core is made by holding i_ack_en.
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_irq_ack <= 1'b0;
      o_taken_src <= '0;
    end
    else
    begin
      if (o_irq_ack && i_irq_valid)
        o_taken_src <= i_irq_src;
      o_irq_ack <= #1 i_irq_valid && i_ack_en && !o_irq_ack;
    end
  end
endmodule : tlic_core_model

// ==== tb/tb_tlic_ctrl.sv ====
// Self-checking testbench of the three-level interrupt controller.
module tb_tlic_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, sfr_wr, bit_wr, bit_wd, ack, reti, ack_en, sd;
  logic bit_rd, valid, wake;
  logic [7:0] sfr_addr, sfr_wd, bit_addr, rdata, wdog;
  logic [11:0] req;
  logic [3:0] src, taken, wev, wcfg;
  logic [1:0] lvl;
  logic [2:0] insvc;
  int n_mismatch, total_checks, cycles;

  // ==========================================================================
  // Design and core model
  tlic_ctrl dut (.i_core_clk(clk), .i_sys_rst(rst), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wd), .o_sfr_rdata(rdata),
    .i_bit_addr(bit_addr), .i_bit_wr(bit_wr), .i_bit_wdata(bit_wd),
    .o_bit_rdata(bit_rd), .i_irq_req(req), .o_irq_valid(valid),
    .o_irq_src(src), .o_irq_level(lvl), .i_irq_ack(ack), .i_reti(reti),
    .o_in_service(insvc), .i_core_shutdown_mode(sd), .i_wake_event(wev),
    .i_wake_cfg(wcfg), .o_core_wake(wake), .o_watchdog_config(wdog));
  tlic_core_model core (.i_core_clk(clk), .i_sys_rst(rst),
    .i_irq_valid(valid), .i_irq_src(src), .i_ack_en(ack_en),
    .o_irq_ack(ack), .o_taken_src(taken));

  // ==========================================================================
  // Clock and hang guard
  // The run needs well under a thousand cycles, so 4000 means a hang.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Helpers
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Every input is set here, so this also gives the values at time zero.
  task do_reset;
    rst = 1'b1;
    {sfr_wr, bit_wr, bit_wd, reti, ack_en, sd} = '0;
    {sfr_addr, sfr_wd, bit_addr, req, wev, wcfg} = '0;
    step(5);
    rst = 1'b0;
  endtask : do_reset
  // Strobes drop and a whole cycle passes, so back-to-back calls never
  // assign a strobe twice in one time step.
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wd = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask : wr
  task wbit(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_wd = v;
    bit_wr = 1'b1;
    step(1);
    bit_wr = 1'b0;
    step(1);
  endtask : wbit
  task rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    step(1);
    check(rdata, exp);
  endtask : rd
  task grant(input logic v, input logic [3:0] s, input logic [1:0] l);
    check({1'b0, valid, lvl, src}, {1'b0, v, l, s});
  endtask : grant

  // ==========================================================================
  // Scenarios
  task t_regs;
    do_reset();
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'hb8, 8'h00);
    rd(8'hc0, 8'h10);
    rd(8'h55, 8'h00);
    check(wdog, 8'h10);
    wbit(8'haf, 1'b1);
    wbit(8'ha9, 1'b1);
    check({7'h0, bit_rd}, 8'h01);
    rd(8'ha8, 8'h82);
    wbit(8'hbf, 1'b1);
    rd(8'hb8, 8'h80);
    check({7'h0, bit_rd}, 8'h01);
    wr(8'ha9, 8'hff);
    rd(8'ha9, 8'hff);
    wr(8'ha9, 8'h00);
    rd(8'ha9, 8'ha0);
    wbit(8'hc4, 1'b0);
    rd(8'hc0, 8'h00);
    check(wdog, 8'h00);
  endtask : t_regs
  // All sources at the low level; adding the next source ahead each round walks
  // the whole polling order backward, supply last on the top level.
  task t_poll;
    do_reset();
    wr(8'ha8, 8'hff);
    wr(8'ha9, 8'h0f);
    for (int i = 11; i >= 0; i--)
    begin
      req = 12'hfff << i;
      step(2);
      grant(1'b1, 4'(i),
            (i == 0) ? tlic_pkg::LVL_TOP : tlic_pkg::LVL_LOW);
    end
    req = 12'h808;
    wr(8'hb8, 8'hff);
    wr(8'ha9, 8'h5f);
    grant(1'b1, 4'hb, tlic_pkg::LVL_HIGH);
    wbit(8'haf, 1'b0);
    check({7'h0, valid}, 8'h00);
  endtask : t_poll
  task t_nest;
    do_reset();
    wr(8'hb8, 8'h04);
    wr(8'ha8, 8'h87);
    ack_en = 1'b1;
    req = 12'h020;
    step(4);
    check({5'h0, insvc}, 8'h01);
    check({4'h0, taken}, 8'h05);
    ack_en = 1'b0;
    req = 12'h060;
    step(3);
    check({7'h0, valid}, 8'h00);
    req = 12'h040;
    reti = 1'b1;
    step(1);
    reti = 1'b0;
    step(2);
    grant(1'b1, 4'h6, tlic_pkg::LVL_LOW);
    ack_en = 1'b1;
    step(4);
    ack_en = 1'b0;
    req = 12'h0c0;
    step(3);
    grant(1'b1, 4'h7, tlic_pkg::LVL_HIGH);
    ack_en = 1'b1;
    step(3);
    ack_en = 1'b0;
    check({5'h0, insvc}, 8'h03);
    req = 12'h0c1;
    step(2);
    check({7'h0, valid}, 8'h00);
    wr(8'ha9, 8'h02);
    grant(1'b1, 4'h0, tlic_pkg::LVL_TOP);
    reti = 1'b1;
    step(1);
    reti = 1'b0;
    step(1);
    check({5'h0, insvc}, 8'h01);
  endtask : t_nest
  task t_sleep;
    do_reset();
    wr(8'ha8, 8'h81);
    sd = 1'b1;
    req = 12'h020;
    wcfg = 4'h2;
    wev = 4'h4;
    step(3);
    check({6'h0, valid, wake}, 8'h00);
    wev = 4'h6;
    step(2);
    check({7'h0, wake}, 8'h01);
    sd = 1'b0;
    step(2);
    check({7'h0, valid}, 8'h01);
    req = 12'h040;
    step(2);
    check({7'h0, valid}, 8'h00);
  endtask : t_sleep

  // ==========================================================================
  // Verdict and main sequence
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    t_regs();
    t_poll();
    t_nest();
    t_sleep();
    report_and_stop();
  end
endmodule : tb_tlic_ctrl
